// File: rtl/dag_pkg.sv
// Purpose: Constants for the direct address generator.
// Assumes: 23-bit data space, 16-bit I/O space.
// Notes: Register offsets are for the plain register port.
package dag_pkg;
  localparam int DAG_DADDR_W = 23;
  localparam int DAG_LOCAL_W = 16;
  localparam int DAG_PAGE_W = 7;
  localparam int DAG_OFS_W = 7;
  localparam int DAG_PDP_W = 9;
  localparam int DAG_IOADDR_W = 16;
  localparam int DAG_BIT_W = 6;
  localparam int DAG_REG_AW = 4;
  // Register indices on the software port.
  localparam logic [3:0] DAG_REG_LOCAL_PAGE = 4'h0;
  localparam logic [3:0] DAG_REG_MAIN_PAGE = 4'h1;
  localparam logic [3:0] DAG_REG_EXT_PAGE = 4'h2;
  localparam logic [3:0] DAG_REG_STACK_PTR = 4'h3;
  localparam logic [3:0] DAG_REG_STACK_PAGE = 4'h4;
  localparam logic [3:0] DAG_REG_EXT_STACK = 4'h5;
  localparam logic [3:0] DAG_REG_PERIPH_PAGE = 4'h6;
  localparam logic [3:0] DAG_REG_MODE = 4'h7;
  localparam logic [3:0] DAG_REG_STATUS = 4'h8;
  // Reset values.
  localparam logic [15:0] DAG_LOCAL_PAGE_RST = 16'h0000;
  localparam logic [6:0] DAG_MAIN_PAGE_RST = 7'h00;
  localparam logic [15:0] DAG_STACK_PTR_RST = 16'h0000;
  localparam logic [6:0] DAG_STACK_PAGE_RST = 7'h00;
  localparam logic [8:0] DAG_PERIPH_PAGE_RST = 9'h000;
  // Memory-mapped register window on page zero.
  localparam logic [22:0] DAG_MMR_LAST = 23'h00_005F;
  // Highest bit positions of register targets.
  localparam logic [5:0] DAG_ACC_TOP_BIT = 6'h27;
  localparam logic [5:0] DAG_REG16_TOP_BIT = 6'h0F;
  // Register-bit target classes (target field bits [3:2] pick class).
  localparam logic [4:0] DAG_TGT_ACC_BASE = 5'h00;
  localparam logic [4:0] DAG_TGT_AUX_BASE = 5'h04;
  localparam logic [4:0] DAG_TGT_TMP_BASE = 5'h0C;
  localparam logic [4:0] DAG_TGT_LIMIT = 5'h10;
  // Status bit positions.
  localparam int DAG_ST_MMR_HIT = 0;
  localparam int DAG_ST_STACK_MMR = 1;
  localparam int DAG_ST_BIT_ERR = 2;
  localparam int DAG_ST_MODE = 3;

  typedef enum logic [2:0] {
    DAG_OP_NONE = 3'b000,
    DAG_OP_DATA = 3'b001,
    DAG_OP_BIT = 3'b010,
    DAG_OP_IO = 3'b011
  } dag_op_t;

  typedef enum logic [1:0] {
    DAG_BOP_TEST = 2'b00,
    DAG_BOP_SET = 2'b01,
    DAG_BOP_CLEAR = 2'b10,
    DAG_BOP_CPL = 2'b11
  } dag_bop_t;
endpackage

// File: rtl/dag_bit_check.sv
// Purpose: Checks a register-bit direct target and bit position.
// Assumes: Target code 0-3 accumulators, 4-11 auxiliary, 12-15 temporary.
// Notes: Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dag_bit_check
  import dag_pkg::*;
(
  input wire logic [4:0] target,
  input wire logic [5:0] bit_offset,
  input wire logic pair,
  output logic target_ok,
  output logic bit_ok,
  output logic [5:0] top_bit
);
  wire logic is_acc;
  wire logic [6:0] last_bit;
  assign target_ok = (target < DAG_TGT_LIMIT);
  assign is_acc = (target < DAG_TGT_AUX_BASE);
  assign top_bit = is_acc ? DAG_ACC_TOP_BIT : DAG_REG16_TOP_BIT;
  // A pair touches the addressed bit and the one above it.
  assign last_bit = {1'b0, bit_offset} + {6'h00, pair};
  assign bit_ok = (last_bit <= {1'b0, top_bit});
endmodule // dag_bit_check
`default_nettype wire

// File: rtl/dag_direct_addr.sv
// Purpose: Direct addressing address generator for data, register-bit and I/O modes.
// Assumes: Decoder presents one request per cycle with req_valid.
// Notes: Outputs are registered one cycle after the request.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Page mode address is main page over local base plus offset.
// - Memory-mapped qualifier forces main page and local base to zero.
// - Local address is the low sixteen bits, same on every page.
// - Stack mode uses stack page over stack pointer plus offset.
// - Stack offset is unsigned, zero through 127.
// - Stack page and pointer load separately or together as one.
// - Registers live at page zero 0 to 5F; stacks belong at 60 upward.
// - Bit offset counts from the least significant bit.
// - Bit address is the offset alone, no pointer or base.
// - Bit mode only for test/set/clear/complement on listed registers.
// - Highest bit is 39 for accumulators, 15 for others.
// - I/O address is peripheral page over seven-bit offset.
// - I/O space is 512 pages of 128 words.
// - Compiler mode bit picks page mode at 0, stack mode at 1.
// - Main page select picks one of 128 main pages.
// - Bit access may touch one bit or an adjacent pair.
module dag_direct_addr
  import dag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_mmap,
  input wire logic [6:0] req_offset,
  input wire logic [4:0] req_target,
  input wire logic [1:0] req_bit_op,
  input wire logic req_pair,
  output logic data_addr_valid,
  output logic [22:0] data_addr,
  output logic io_addr_valid,
  output logic [15:0] io_addr,
  output logic bit_valid,
  output logic [4:0] bit_target,
  output logic [5:0] bit_addr,
  output logic [1:0] bit_op,
  output logic bit_pair,
  output logic bit_error
);
  logic [15:0] local_page_base_reg;
  logic [6:0] main_page_select_reg;
  logic [15:0] data_stack_pointer_reg;
  logic [6:0] stack_page_register_reg;
  logic [8:0] peripheral_page_register_reg;
  logic compiler_mode_bit_reg;
  logic mmr_hit_reg;
  logic stack_mmr_reg;
  logic data_addr_valid_reg;
  logic [22:0] data_addr_reg;
  logic io_addr_valid_reg;
  logic [15:0] io_addr_reg;
  logic bit_valid_reg;
  logic [4:0] bit_target_reg;
  logic [5:0] bit_addr_reg;
  logic [1:0] bit_op_reg;
  logic bit_pair_reg;
  logic bit_error_reg;
  logic [31:0] reg_rdata_reg;
  logic [31:0] reg_rdata_next;

  wire logic is_data;
  wire logic is_bit;
  wire logic is_io;
  wire logic stack_mode;
  wire logic [6:0] eff_page;
  wire logic [15:0] eff_base;
  wire logic [15:0] local_sum;
  wire logic [22:0] data_addr_next;
  wire logic [15:0] io_addr_next;
  wire logic tgt_ok;
  wire logic bit_in_range;
  wire logic bit_error_next;
  wire logic mmr_window_next;
  wire logic wr_local;
  wire logic wr_main;
  wire logic wr_ext_page;
  wire logic wr_sp;
  wire logic wr_sph;
  wire logic wr_ext_stack;
  wire logic wr_pdp;
  wire logic wr_mode;

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] idx);
    reg_hit = (addr == idx);
  endfunction

  // Request decode.
  assign is_data = req_valid && (req_op == DAG_OP_DATA);
  assign is_bit = req_valid && (req_op == DAG_OP_BIT);
  assign is_io = req_valid && (req_op == DAG_OP_IO);
  // Memory-mapped accesses always use page mode at page zero.
  assign stack_mode = compiler_mode_bit_reg && !req_mmap;

  // Page and base selection.
  assign eff_page = req_mmap ? 7'h00 :
                    stack_mode ? stack_page_register_reg : main_page_select_reg;
  assign eff_base = req_mmap ? 16'h0000 :
                    stack_mode ? data_stack_pointer_reg : local_page_base_reg;
  // The sum is held to 16 bits so a carry never bumps the page.
  assign local_sum = eff_base + {9'h000, req_offset};
  assign data_addr_next = {eff_page, local_sum};
  assign mmr_window_next = (data_addr_next <= DAG_MMR_LAST);

  // I/O page concatenation.
  assign io_addr_next = {peripheral_page_register_reg, req_offset};

  // Register-bit target check; bit address ignores pointers and bases.
  dag_bit_check u_bit_check (
    .target(req_target),
    .bit_offset(req_offset[5:0]),
    .pair(req_pair),
    .target_ok(tgt_ok),
    .bit_ok(bit_in_range),
    .top_bit()
  );
  assign bit_error_next = !tgt_ok || !bit_in_range || req_offset[6];

  // Register port write decode.
  assign wr_local = reg_wr && reg_hit(reg_addr, DAG_REG_LOCAL_PAGE);
  assign wr_main = reg_wr && reg_hit(reg_addr, DAG_REG_MAIN_PAGE);
  assign wr_ext_page = reg_wr && reg_hit(reg_addr, DAG_REG_EXT_PAGE);
  assign wr_sp = reg_wr && reg_hit(reg_addr, DAG_REG_STACK_PTR);
  assign wr_sph = reg_wr && reg_hit(reg_addr, DAG_REG_STACK_PAGE);
  assign wr_ext_stack = reg_wr && reg_hit(reg_addr, DAG_REG_EXT_STACK);
  assign wr_pdp = reg_wr && reg_hit(reg_addr, DAG_REG_PERIPH_PAGE);
  assign wr_mode = reg_wr && reg_hit(reg_addr, DAG_REG_MODE);

  // Page registers: separate or combined loads.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      local_page_base_reg <= DAG_LOCAL_PAGE_RST;
      main_page_select_reg <= DAG_MAIN_PAGE_RST;
    end else if (wr_ext_page) begin
      local_page_base_reg <= reg_wdata[15:0];
      main_page_select_reg <= reg_wdata[22:16];
    end else begin
      if (wr_local) local_page_base_reg <= reg_wdata[15:0];
      if (wr_main) main_page_select_reg <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_stack_pointer_reg <= DAG_STACK_PTR_RST;
      stack_page_register_reg <= DAG_STACK_PAGE_RST;
    end else if (wr_ext_stack) begin
      data_stack_pointer_reg <= reg_wdata[15:0];
      stack_page_register_reg <= reg_wdata[22:16];
    end else begin
      if (wr_sp) data_stack_pointer_reg <= reg_wdata[15:0];
      if (wr_sph) stack_page_register_reg <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      peripheral_page_register_reg <= DAG_PERIPH_PAGE_RST;
      compiler_mode_bit_reg <= 1'b0;
    end else begin
      if (wr_pdp) peripheral_page_register_reg <= reg_wdata[8:0];
      if (wr_mode) compiler_mode_bit_reg <= reg_wdata[0];
    end
  end

  // Data address outputs.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_addr_valid_reg <= 1'b0;
      data_addr_reg <= 23'h00_0000;
    end else begin
      data_addr_valid_reg <= is_data;
      if (is_data) data_addr_reg <= data_addr_next;
    end
  end

  // Sticky diagnostics: hardware set wins over a software clear.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mmr_hit_reg <= 1'b0;
      stack_mmr_reg <= 1'b0;
    end else begin
      mmr_hit_reg <= (is_data && req_mmap) ||
                     (mmr_hit_reg && !(wr_mode && reg_wdata[1]));
      // A stack access landing in the register window breaks the placement convention.
      stack_mmr_reg <= (is_data && stack_mode && mmr_window_next) ||
                       (stack_mmr_reg && !(wr_mode && reg_wdata[2]));
    end
  end

  // I/O address outputs.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      io_addr_valid_reg <= 1'b0;
      io_addr_reg <= 16'h0000;
    end else begin
      io_addr_valid_reg <= is_io;
      if (is_io) io_addr_reg <= io_addr_next;
    end
  end

  // Register-bit outputs.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bit_valid_reg <= 1'b0;
      bit_target_reg <= 5'h00;
      bit_addr_reg <= 6'h00;
      bit_op_reg <= 2'b00;
      bit_pair_reg <= 1'b0;
      bit_error_reg <= 1'b0;
    end else begin
      bit_valid_reg <= is_bit && !bit_error_next;
      bit_error_reg <= is_bit && bit_error_next;
      if (is_bit) begin
        bit_target_reg <= req_target;
        bit_addr_reg <= req_offset[5:0];
        bit_op_reg <= req_bit_op;
        bit_pair_reg <= req_pair;
      end
    end
  end

  // Read mux; unmapped indices read zero.
  always_comb begin
    reg_rdata_next = 32'h0000_0000;
    case (reg_addr)
      DAG_REG_LOCAL_PAGE: reg_rdata_next = {16'h0000, local_page_base_reg};
      DAG_REG_MAIN_PAGE: reg_rdata_next = {25'h000_0000, main_page_select_reg};
      DAG_REG_EXT_PAGE: reg_rdata_next = {9'h000, main_page_select_reg, local_page_base_reg};
      DAG_REG_STACK_PTR: reg_rdata_next = {16'h0000, data_stack_pointer_reg};
      DAG_REG_STACK_PAGE: reg_rdata_next = {25'h000_0000, stack_page_register_reg};
      DAG_REG_EXT_STACK:
        reg_rdata_next = {9'h000, stack_page_register_reg, data_stack_pointer_reg};
      DAG_REG_PERIPH_PAGE: reg_rdata_next = {23'h00_0000, peripheral_page_register_reg};
      DAG_REG_MODE: reg_rdata_next = {31'h0000_0000, compiler_mode_bit_reg};
      DAG_REG_STATUS: begin
        reg_rdata_next[DAG_ST_MMR_HIT] = mmr_hit_reg;
        reg_rdata_next[DAG_ST_STACK_MMR] = stack_mmr_reg;
        reg_rdata_next[DAG_ST_BIT_ERR] = bit_error_reg;
        reg_rdata_next[DAG_ST_MODE] = compiler_mode_bit_reg;
      end
      default: reg_rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (!resetn) reg_rdata_reg <= 32'h0000_0000;
    else reg_rdata_reg <= reg_rd ? reg_rdata_next : 32'h0000_0000;
  end

  assign reg_rdata = reg_rdata_reg;
  assign data_addr_valid = data_addr_valid_reg;
  assign data_addr = data_addr_reg;
  assign io_addr_valid = io_addr_valid_reg;
  assign io_addr = io_addr_reg;
  assign bit_valid = bit_valid_reg;
  assign bit_target = bit_target_reg;
  assign bit_addr = bit_addr_reg;
  assign bit_op = bit_op_reg;
  assign bit_pair = bit_pair_reg;
  assign bit_error = bit_error_reg;
endmodule // dag_direct_addr
`default_nettype wire

// File: testbench/dag_props.sv
// Purpose: Port assertions for the direct address generator.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to the design from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module dag_props
  import dag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_mmap,
  input wire logic [6:0] req_offset,
  input wire logic [4:0] req_target,
  input wire logic [1:0] req_bit_op,
  input wire logic req_pair,
  input wire logic data_addr_valid,
  input wire logic [22:0] data_addr,
  input wire logic io_addr_valid,
  input wire logic [15:0] io_addr,
  input wire logic bit_valid,
  input wire logic [4:0] bit_target,
  input wire logic [5:0] bit_addr,
  input wire logic [1:0] bit_op,
  input wire logic bit_pair,
  input wire logic bit_error
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence data_req;
    req_valid && req_op == 3'h1;
  endsequence
  sequence bit_req;
    req_valid && req_op == 3'h2;
  endsequence
  sequence io_req;
    req_valid && req_op == 3'h3;
  endsequence
  data_pulse_a: assert property (data_req |=> data_addr_valid)
    else $error("data address strobe missing");
  data_quiet_a: assert property (!(req_valid && req_op == 3'h1) |=> !data_addr_valid)
    else $error("data address strobe without request");
  mmap_page_a: assert property (
    data_req ##0 req_mmap |=> data_addr == {16'h0000, $past(req_offset)})
    else $error("register access left page zero");
  io_addr_a: assert property (
    io_req |=> io_addr_valid && io_addr[6:0] == $past(req_offset))
    else $error("io offset not in low address bits");
  io_quiet_a: assert property (!(req_valid && req_op == 3'h3) |=> !io_addr_valid)
    else $error("io address strobe without request");
  bit_quiet_a: assert property (
    !(req_valid && req_op == 3'h2) |=> !bit_valid && !bit_error)
    else $error("bit strobe without request");
  bit_one_a: assert property (bit_req |=> bit_valid != bit_error)
    else $error("bit request answered wrongly");
  bit_pos_a: assert property (bit_req |=> bit_addr == $past(req_offset[5:0]))
    else $error("bit address not the offset");
  acc_top_a: assert property (
    bit_req ##0 (req_target < 5'h04 && req_offset[5:0] > 6'h27) |=> bit_error)
    else $error("accumulator bit past top accepted");
  reg_top_a: assert property (
    bit_req ##0 (req_target[4] == 1'b0 && req_target > 5'h03 && req_offset[5:0] > 6'h0F)
    |=> bit_error)
    else $error("register bit past top accepted");
  bad_tgt_a: assert property (bit_req ##0 req_target > 5'h0F |=> bit_error && !bit_valid)
    else $error("illegal bit target accepted");
  // Read data must be zero outside its one-cycle slot, or a bus mux downstream sees stale values.
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule // dag_props
`default_nettype wire

// File: testbench/dag_enc_model.sv
// Purpose: Instruction encoder model that forms direct offsets.
// Assumes: Purely combinational, like an assembler's arithmetic.
// Notes: Drives the offset that the bench hands to the design.
`timescale 1ns/1ps
`default_nettype none
module dag_enc_model (
  input wire logic [15:0] local_addr,
  input wire logic [15:0] assumed_page_base,
  input wire logic mmap,
  output logic [6:0] ofs
);
  wire logic [15:0] diff;
  assign diff = local_addr - assumed_page_base;
  // Register offsets ignore the assumed base, so page-zero registers stay reachable.
  assign ofs = mmap ? local_addr[6:0] : diff[6:0];
endmodule // dag_enc_model
`default_nettype wire

// File: testbench/tb.sv
// Purpose: Self-checking bench for the direct address generator.
// Assumes: Outputs answer exactly one cycle after the request.
// Notes: Fixed one-cycle waits follow the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb;
  import dag_pkg::*;
  logic ref_clk, resetn, reg_wr, reg_rd, req_valid, req_mmap, req_pair, e_mmap;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] req_op;
  logic [6:0] req_offset, e_ofs;
  logic [4:0] req_target, bit_target;
  logic [1:0] req_bit_op, bit_op;
  logic data_addr_valid, io_addr_valid, bit_valid, bit_pair, bit_error;
  logic [22:0] data_addr;
  logic [15:0] io_addr, e_addr, e_base;
  logic [5:0] bit_addr;
  int fails = 0;
  int samples_checked = 0;
  dag_direct_addr dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_op(req_op), .req_mmap(req_mmap), .req_offset(req_offset), .req_target(req_target),
    .req_bit_op(req_bit_op), .req_pair(req_pair), .data_addr_valid(data_addr_valid),
    .data_addr(data_addr), .io_addr_valid(io_addr_valid), .io_addr(io_addr),
    .bit_valid(bit_valid), .bit_target(bit_target), .bit_addr(bit_addr), .bit_op(bit_op),
    .bit_pair(bit_pair), .bit_error(bit_error)
  );
  dag_enc_model enc (.local_addr(e_addr), .assumed_page_base(e_base), .mmap(e_mmap), .ofs(e_ofs));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic req(input logic [2:0] op, input logic mm, input logic [6:0] o,
                     input logic [4:0] tg, input logic [1:0] bo, input logic pr);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_mmap <= mm;
    req_offset <= o;
    req_target <= tg;
    req_bit_op <= bo;
    req_pair <= pr;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
  endtask
  task automatic dreq(input logic [15:0] la, input logic [15:0] pb, input logic mm,
                      input logic [22:0] e);
    e_addr = la;
    e_base = pb;
    e_mmap = mm;
    #1;
    req(3'h1, mm, e_ofs, 5'h00, 2'h0, 1'b0);
    `CHK("data_addr_valid", 1'b1, data_addr_valid)
    `CHK("data_addr", e, data_addr)
  endtask
  task automatic breq(input logic [4:0] tg, input logic [5:0] bp, input logic pr,
                      input logic [1:0] bo, input logic ok);
    req(3'h2, 1'b0, {1'b0, bp}, tg, bo, pr);
    `CHK("bit_valid", ok, bit_valid)
    `CHK("bit_error", ~ok, bit_error)
    if (ok) begin
      `CHK("bit_addr", bp, bit_addr)
      `CHK("bit_target", tg, bit_target)
      `CHK("bit_op", bo, bit_op)
      `CHK("bit_pair", pr, bit_pair)
    end
  endtask
  task automatic ioreq(input logic [6:0] o, input logic [15:0] e);
    req(3'h3, 1'b0, o, 5'h00, 2'h0, 1'b0);
    `CHK("io_addr_valid", 1'b1, io_addr_valid)
    `CHK("io_addr", e, io_addr)
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, req_valid, req_mmap, req_pair, e_mmap} = '0;
    {reg_addr, reg_wdata, req_op, req_offset, req_target, req_bit_op, e_addr, e_base} = '0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], 32'h0000_0000);
    end
    wr(DAG_REG_EXT_PAGE, 32'h0003_FFF0);
    rd(DAG_REG_MAIN_PAGE, 32'h0000_0003);
    rd(DAG_REG_LOCAL_PAGE, 32'h0000_FFF0);
    dreq(16'hFFF4, 16'hFFF0, 1'b0, 23'h03_FFF4);
    dreq(16'h0010, 16'hFFF0, 1'b1, 23'h00_0010);
    wr(DAG_REG_LOCAL_PAGE, 32'h0000_FFFF);
    dreq(16'h0001, 16'h0000, 1'b0, 23'h03_0000);
    wr(DAG_REG_MAIN_PAGE, 32'h0000_007F);
    dreq(16'h0005, 16'h0000, 1'b0, 23'h7F_0004);
    wr(DAG_REG_STACK_PTR, 32'h0000_0060);
    wr(DAG_REG_STACK_PAGE, 32'h0000_0005);
    rd(DAG_REG_EXT_STACK, 32'h0005_0060);
    wr(DAG_REG_MODE, 32'h0000_0001);
    dreq(16'h007F, 16'h0000, 1'b0, 23'h05_00DF);
    dreq(16'h0000, 16'h0000, 1'b0, 23'h05_0060);
    wr(DAG_REG_EXT_STACK, 32'h0002_FFF0);
    rd(DAG_REG_STACK_PAGE, 32'h0000_0002);
    rd(DAG_REG_STACK_PTR, 32'h0000_FFF0);
    dreq(16'h007F, 16'h0000, 1'b0, 23'h02_006F);
    breq(5'h00, 6'h00, 1'b0, DAG_BOP_TEST, 1'b1);
    breq(5'h03, 6'h27, 1'b0, DAG_BOP_SET, 1'b1);
    breq(5'h03, 6'h28, 1'b0, DAG_BOP_SET, 1'b0);
    breq(5'h04, 6'h0F, 1'b0, DAG_BOP_CLEAR, 1'b1);
    breq(5'h0B, 6'h10, 1'b0, DAG_BOP_CLEAR, 1'b0);
    breq(5'h0C, 6'h0E, 1'b1, DAG_BOP_CPL, 1'b1);
    breq(5'h0F, 6'h0F, 1'b1, DAG_BOP_CPL, 1'b0);
    breq(5'h10, 6'h00, 1'b0, DAG_BOP_TEST, 1'b0);
    wr(DAG_REG_MODE, 32'h0000_0000);
    dreq(16'h0004, 16'h0000, 1'b0, 23'h7F_0003);
    wr(DAG_REG_PERIPH_PAGE, 32'h0000_01FF);
    ioreq(7'h7F, 16'hFFFF);
    wr(DAG_REG_PERIPH_PAGE, 32'h0000_0001);
    ioreq(7'h00, 16'h0080);
    req(3'h5, 1'b0, 7'h01, 5'h00, 2'h0, 1'b0);
    `CHK("data_addr_valid", 1'b0, data_addr_valid)
    `CHK("io_addr_valid", 1'b0, io_addr_valid)
    `CHK("bit_valid", 1'b0, bit_valid)
    `CHK("bit_error", 1'b0, bit_error)
    req(3'h2, 1'b0, 7'h4E, 5'h0C, 2'h3, 1'b1);
    `CHK("bit_error", 1'b1, bit_error)
    `CHK("bit_valid", 1'b0, bit_valid)
    wr(DAG_REG_MODE, 32'h0000_0001);
    wr(DAG_REG_EXT_STACK, 32'h0000_0000);
    dreq(16'h0010, 16'h0000, 1'b0, 23'h00_0010);
    rd(DAG_REG_STATUS, 32'h0000_000B);
    wr(DAG_REG_MODE, 32'h0000_0006);
    rd(DAG_REG_STATUS, 32'h0000_0000);
    // A reset in mid-run must clear every held output and page register.
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    `CHK("data_addr", 23'h00_0000, data_addr)
    `CHK("io_addr", 16'h0000, io_addr)
    `CHK("bit_target", 5'h00, bit_target)
    `CHK("bit_addr", 6'h00, bit_addr)
    `CHK("bit_op", 2'h0, bit_op)
    `CHK("bit_pair", 1'b0, bit_pair)
    rd(DAG_REG_EXT_PAGE, 32'h0000_0000);
    rd(DAG_REG_PERIPH_PAGE, 32'h0000_0000);
    rd(DAG_REG_EXT_STACK, 32'h0000_0000);
    stop_test;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    stop_test;
  end
endmodule // tb
bind dag_direct_addr dag_props chk (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req_op(req_op), .req_mmap(req_mmap), .req_offset(req_offset), .req_target(req_target),
  .req_bit_op(req_bit_op), .req_pair(req_pair), .data_addr_valid(data_addr_valid),
  .data_addr(data_addr), .io_addr_valid(io_addr_valid), .io_addr(io_addr),
  .bit_valid(bit_valid), .bit_target(bit_target), .bit_addr(bit_addr), .bit_op(bit_op),
  .bit_pair(bit_pair), .bit_error(bit_error)
);
`default_nettype wire
